/* File: gpe_pkg.sv */
// gpio port package: register map, field layouts, reset values
package gpe_pkg;
  localparam int          PIN_N        = 8;
  localparam logic [11:0] OFS_DATA     = 12'h000;
  localparam logic [11:0] OFS_DIR      = 12'h004;
  localparam logic [11:0] OFS_OPT      = 12'h008;
  localparam logic [11:0] OFS_SENS     = 12'h00C;
  localparam logic [11:0] OFS_IRQ_PIN  = 12'h010;
  localparam logic [11:0] OFS_PULL_PIN = 12'h014;
  localparam logic [7:0]  RST_DIR      = 8'h00;
  localparam logic [7:0]  RST_OPT      = 8'h00;
  localparam logic [7:0]  RST_DATA     = 8'h00;
  localparam logic [1:0]  RST_SENS     = 2'h0;
  localparam int          SENS_W       = 2;
  // sensitivity encodings
  localparam logic [1:0]  SENS_FALL_LOW = 2'h0;
  localparam logic [1:0]  SENS_RISE     = 2'h1;
  localparam logic [1:0]  SENS_FALL     = 2'h2;
  localparam logic [1:0]  SENS_BOTH     = 2'h3;
  typedef enum logic [1:0] {
    GPE_IN_FLOAT,
    GPE_IN_PULL,
    GPE_OUT_OD,
    GPE_OUT_PP
  } gpe_mode_e;
endpackage

/* File: gpe_edge_det.sv */
// gpio port per-pin event detector for the interrupt group
`timescale 1ns/100ps
`default_nettype none
module gpe_edge_det #(
  parameter int N = 8
) (
  // clock and reset
  input  wire  logic         pclk,
  input  wire  logic         presetn,
  input  wire  logic         clk_en,
  // pin levels and selection
  input  wire  logic [N-1:0] level,
  input  wire  logic [N-1:0] enable,
  input  wire  logic [1:0]   sens,
  // detected event, or of all pins
  output logic               event_any
);
  logic [N-1:0] prev_r;
  logic [N-1:0] hit;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prev_r <= {N{1'b1}};
    else if (clk_en)
      prev_r <= level;

  // per-pin detection, then or onto one line
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      always_comb
      begin
        unique case (sens)
          gpe_pkg::SENS_FALL_LOW: hit[g] = enable[g] & ~level[g];
          gpe_pkg::SENS_RISE:     hit[g] = enable[g] & level[g] & ~prev_r[g];
          gpe_pkg::SENS_FALL:     hit[g] = enable[g] & ~level[g] & prev_r[g];
          gpe_pkg::SENS_BOTH:     hit[g] = enable[g] & (level[g] ^ prev_r[g]);
        endcase
      end
    end
  endgenerate

  assign event_any = |hit;
endmodule // gpe_edge_det
`default_nettype wire

/* File: gpe_port.sv */
// gpio port with external interrupt group, apb register slave
`timescale 1ns/100ps
`default_nettype none
module gpe_port #(
  parameter int         N        = 8,
  parameter logic [7:0] IRQ_PINS = 8'h0F,
  parameter logic [7:0] PULL_OK  = 8'hFF
) (
  // clock and reset
  input  wire  logic         pclk,
  input  wire  logic         presetn,
  input  wire  logic         clk_en,
  // apb slave
  input  wire  logic         psel,
  input  wire  logic         penable,
  input  wire  logic         pwrite,
  input  wire  logic [11:0]  paddr,
  input  wire  logic [31:0]  pwdata,
  input  wire  logic [3:0]   pstrb,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // pins
  input  wire  logic [N-1:0] pin_in,
  output logic [N-1:0]       pin_out,
  output logic [N-1:0]       pin_oe,
  output logic [N-1:0]       pin_pullup,
  // alternate function
  input  wire  logic [N-1:0] alt_en,
  input  wire  logic [N-1:0] alt_drive,
  input  wire  logic [N-1:0] alt_out,
  input  wire  logic [N-1:0] alt_pp,
  output logic [N-1:0]       alt_in,
  // external interrupt
  input  wire  logic         vector_fetch,
  output logic               ext_irq_req
);
  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  logic [N-1:0] port_pin_data_r;
  logic [N-1:0] port_pin_direction_r;
  logic [N-1:0] port_pin_option_r;
  logic [1:0]   ext_irq_sensitivity_ctrl_r;
  logic         irq_latch_r;
  logic         irq_latch_nxt;
  logic         wr_en;
  logic         rd_en;
  logic         rd_loaded_r;
  logic         addr_ok;
  logic [31:0]  rd_mux;
  logic [N-1:0] data_view;
  logic [N-1:0] irq_pin_en;
  logic         det_event;
  logic         sens_wr;
  logic [N-1:0] pin_out_r;
  logic [N-1:0] pin_oe_r;
  logic [N-1:0] pin_pullup_r;

  function automatic gpe_pkg::gpe_mode_e pin_mode(input logic d, input logic o);
    unique case ({d, o})
      2'h0: pin_mode = gpe_pkg::GPE_IN_FLOAT;
      2'h1: pin_mode = gpe_pkg::GPE_IN_PULL;
      2'h2: pin_mode = gpe_pkg::GPE_OUT_OD;
      2'h3: pin_mode = gpe_pkg::GPE_OUT_PP;
    endcase
  endfunction

  //--------------------------------------------------------------
  // apb decode
  //--------------------------------------------------------------
  always_comb
  begin
    unique case (paddr)
      gpe_pkg::OFS_DATA, gpe_pkg::OFS_DIR, gpe_pkg::OFS_OPT,
      gpe_pkg::OFS_SENS, gpe_pkg::OFS_IRQ_PIN, gpe_pkg::OFS_PULL_PIN:
        addr_ok = 1'b1;
      default:
        addr_ok = 1'b0;
    endcase
  end

  // frozen clock or unloaded read holds the access phase
  assign pready  = clk_en & (pwrite | rd_loaded_r);
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_en   = psel & penable & pwrite & addr_ok & pstrb[0] & clk_en;
  assign rd_en   = psel & ~pwrite & clk_en & ~rd_loaded_r;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rd_loaded_r <= 1'b0;
    else if (clk_en)
      rd_loaded_r <= psel & ~pwrite & ~(penable & rd_loaded_r);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      port_pin_direction_r <= gpe_pkg::RST_DIR;
      port_pin_option_r    <= gpe_pkg::RST_OPT;
    end
    else if (wr_en)
    begin
      if (paddr == gpe_pkg::OFS_DIR)
        port_pin_direction_r <= pwdata[N-1:0];
      if (paddr == gpe_pkg::OFS_OPT)
        port_pin_option_r <= pwdata[N-1:0];
    end

  // latch always written, pin unchanged in input mode
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      port_pin_data_r <= gpe_pkg::RST_DATA;
    else if (wr_en && paddr == gpe_pkg::OFS_DATA)
      port_pin_data_r <= pwdata[N-1:0];

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ext_irq_sensitivity_ctrl_r <= gpe_pkg::RST_SENS;
    else if (wr_en && paddr == gpe_pkg::OFS_SENS)
      ext_irq_sensitivity_ctrl_r <= pwdata[gpe_pkg::SENS_W-1:0];

  //--------------------------------------------------------------
  // read path
  //--------------------------------------------------------------
  // input pins read the pin, output pins the latch
  assign data_view = (port_pin_direction_r & port_pin_data_r)
                   | (~port_pin_direction_r & pin_in);

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      gpe_pkg::OFS_DATA:     rd_mux[N-1:0] = data_view;
      gpe_pkg::OFS_DIR:      rd_mux[N-1:0] = port_pin_direction_r;
      gpe_pkg::OFS_OPT:      rd_mux[N-1:0] = port_pin_option_r;
      gpe_pkg::OFS_SENS:     rd_mux[1:0]   = ext_irq_sensitivity_ctrl_r;
      gpe_pkg::OFS_IRQ_PIN:  rd_mux[N-1:0] = IRQ_PINS[N-1:0];
      gpe_pkg::OFS_PULL_PIN: rd_mux[N-1:0] = PULL_OK[N-1:0];
      default:               rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
      prdata <= rd_mux;

  //--------------------------------------------------------------
  // pin drivers
  //--------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_pin
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
          pin_out_r[g]    <= 1'b0;
          pin_oe_r[g]     <= 1'b0;
          pin_pullup_r[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          if (alt_en[g] && alt_drive[g])
          begin
            // peripheral owns the pin in its own style
            pin_out_r[g]    <= alt_out[g];
            pin_oe_r[g]     <= alt_pp[g] | ~alt_out[g];
            pin_pullup_r[g] <= 1'b0;
          end
          else
          begin
            unique case (pin_mode(port_pin_direction_r[g], port_pin_option_r[g]))
              gpe_pkg::GPE_IN_FLOAT:
              begin
                pin_out_r[g]    <= 1'b0;
                pin_oe_r[g]     <= 1'b0;
                pin_pullup_r[g] <= 1'b0;
              end
              gpe_pkg::GPE_IN_PULL:
              begin
                pin_out_r[g]    <= 1'b0;
                pin_oe_r[g]     <= 1'b0;
                pin_pullup_r[g] <= PULL_OK[g];
              end
              gpe_pkg::GPE_OUT_OD:
              begin
                pin_out_r[g]    <= 1'b0;
                pin_oe_r[g]     <= ~port_pin_data_r[g];
                pin_pullup_r[g] <= 1'b0;
              end
              gpe_pkg::GPE_OUT_PP:
              begin
                pin_out_r[g]    <= port_pin_data_r[g];
                pin_oe_r[g]     <= 1'b1;
                pin_pullup_r[g] <= 1'b0;
              end
            endcase
          end
        end
    end
  endgenerate

  assign pin_out    = pin_out_r;
  assign pin_oe     = pin_oe_r;
  assign pin_pullup = pin_pullup_r;
  assign alt_in     = pin_in;

  //--------------------------------------------------------------
  // external interrupt
  //--------------------------------------------------------------
  // interrupt input is direction 0, option 1 on capable pins
  assign irq_pin_en = IRQ_PINS[N-1:0] & ~port_pin_direction_r
                    & port_pin_option_r;

  gpe_edge_det #(
    .N (N)
  ) u_det (
    .pclk      (pclk),
    .presetn   (presetn),
    .clk_en    (clk_en),
    .level     (pin_in),
    .enable    (irq_pin_en),
    .sens      (ext_irq_sensitivity_ctrl_r),
    .event_any (det_event)
  );

  assign sens_wr = wr_en && paddr == gpe_pkg::OFS_SENS
                && pwdata[1:0] != ext_irq_sensitivity_ctrl_r;

  // set beats fetch clear; sensitivity change discards
  always_comb
  begin
    irq_latch_nxt = irq_latch_r;
    if (vector_fetch)
      irq_latch_nxt = 1'b0;
    if (det_event)
      irq_latch_nxt = 1'b1;
    if (sens_wr)
      irq_latch_nxt = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq_latch_r <= 1'b0;
    else if (clk_en)
      irq_latch_r <= irq_latch_nxt;

  assign ext_irq_req = irq_latch_r;

  //--------------------------------------------------------------
  // assertions
  //--------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_IN_READ: assert property (
    rd_en && paddr == gpe_pkg::OFS_DATA ##1 1'b1
    |-> (prdata[N-1:0] & ~$past(port_pin_direction_r)) == ($past(pin_in) & ~$past(port_pin_direction_r)))
    else $error("input pin read not pin level");
  AST_OUT_READ: assert property (
    rd_en && paddr == gpe_pkg::OFS_DATA |=>
    (prdata[N-1:0] & $past(port_pin_direction_r)) == ($past(port_pin_data_r) & $past(port_pin_direction_r)))
    else $error("output pin read not latch");
  AST_IN_NO_DRIVE: assert property (
    clk_en && port_pin_direction_r == '0 && alt_en == '0 |=> pin_oe == '0)
    else $error("input pin driven");
  AST_PP_DRIVE: assert property (
    clk_en && port_pin_direction_r[0] && port_pin_option_r[0] && !alt_en[0]
    |=> pin_oe[0] && pin_out[0] == $past(port_pin_data_r[0]))
    else $error("push-pull drive wrong");
  AST_OD_DRIVE: assert property (
    clk_en && port_pin_direction_r[0] && !port_pin_option_r[0] && !alt_en[0]
    |=> pin_oe[0] == !$past(port_pin_data_r[0]) && !pin_out[0])
    else $error("open-drain drive wrong");
  AST_ALT_DRIVE: assert property (
    clk_en && alt_en[0] && alt_drive[0] && alt_pp[0] |=> pin_oe[0] && pin_out[0] == $past(alt_out[0]))
    else $error("peripheral override lost");
  AST_RESET_DIR: assert property (
    $rose(presetn) |-> port_pin_direction_r == '0 && port_pin_option_r == '0)
    else $error("direction not cleared");
  AST_SENS_CANCEL: assert property (
    clk_en && sens_wr |=> !ext_irq_req)
    else $error("pending request not discarded");
  AST_FETCH_CLEAR: assert property (
    clk_en && vector_fetch && !det_event && !sens_wr |=> !ext_irq_req)
    else $error("fetch did not clear request");
  AST_EVENT_SET: assert property (
    clk_en && det_event && !sens_wr |=> ext_irq_req)
    else $error("event not latched");
  AST_FLOAT_IN: assert property (
    clk_en && !port_pin_direction_r[0] && !port_pin_option_r[0] && !alt_en[0]
    |=> !pin_oe[0] && !pin_pullup[0])
    else $error("floating input driven or pulled");
  AST_PULL_IN: assert property (
    clk_en && !port_pin_direction_r[1] && port_pin_option_r[1] && !alt_en[1]
    |=> !pin_oe[1] && pin_pullup[1] == PULL_OK[1])
    else $error("pull-up input wrong");
  AST_PULL_OUT: assert property (
    clk_en && port_pin_direction_r[0] && !alt_en[0] |=> !pin_pullup[0])
    else $error("output pin pulled up");
  AST_DATA_WRITE: assert property (
    wr_en && paddr == gpe_pkg::OFS_DATA |=> port_pin_data_r == $past(pwdata[N-1:0]))
    else $error("data latch not written");
  AST_DIR_WRITE: assert property (
    wr_en && paddr == gpe_pkg::OFS_DIR |=> port_pin_direction_r == $past(pwdata[N-1:0]))
    else $error("direction not written");
  AST_ALT_OD: assert property (
    clk_en && alt_en[2] && alt_drive[2] && !alt_pp[2]
    |=> pin_oe[2] == !$past(alt_out[2]) && pin_out[2] == $past(alt_out[2]))
    else $error("peripheral open-drain wrong");
  AST_FETCH_EVENT: assert property (
    clk_en && vector_fetch && det_event && !sens_wr |=> ext_irq_req)
    else $error("new event lost to fetch");
  AST_SENS_SAME: assert property (
    wr_en && paddr == gpe_pkg::OFS_SENS && !sens_wr && irq_latch_r && !vector_fetch
    |=> ext_irq_req)
    else $error("unchanged sensitivity discarded request");
  AST_NO_EVENT_OUTPUT: assert property (
    port_pin_direction_r == {N{1'b1}} |-> !det_event)
    else $error("output pins raised event");
  AST_FROZEN_WAIT: assert property (
    !clk_en |-> !pready)
    else $error("transfer completed while frozen");
  AST_RESET_OUT: assert property (
    $rose(presetn) |-> pin_oe == '0 && pin_pullup == '0 && !ext_irq_req)
    else $error("outputs not idle after reset");
  AST_LEVEL_EVENT: assert property (
    ext_irq_sensitivity_ctrl_r == gpe_pkg::SENS_FALL_LOW && (irq_pin_en & ~pin_in) != '0
    |-> det_event)
    else $error("low level not detected");

  COV_IRQ:   cover property (det_event ##1 ext_irq_req ##[1:20] vector_fetch);
  COV_OD:    cover property (port_pin_direction_r[0] && !port_pin_option_r[0]);
  COV_ALT:   cover property (alt_en[0] && alt_drive[0]);
  COV_CANCEL: cover property (ext_irq_req && sens_wr);
  COV_READ_IN: cover property (rd_en && paddr == gpe_pkg::OFS_DATA && !port_pin_direction_r[0]);
endmodule // gpe_port
`default_nettype wire

/* File: gpe_pin_model.sv */
// board-side pin model for the gpio port bench
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pin level resolution
// ----------------------------------------
module gpe_pin_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // device side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pullup,
  // board drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  // resolved level
  output logic [7:0]      pin_in
);
  logic [7:0] flt_r;

  // undriven pin wanders each cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flt_r <= 8'h00;
    else
      flt_r <= ~flt_r;
  end

  // released open-drain pin floats
  always_comb
  begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] : pin_pullup[i] | flt_r[i];
  end
endmodule // gpe_pin_model
`default_nettype wire

/* File: gpe_port_tb.sv */
// self-checking bench for the gpio port
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module gpe_port_tb;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, vector_fetch;
  logic        pready, pslverr, ext_irq_req, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup, alt_in, ext_en, ext_val;
  logic [7:0]  alt_en, alt_drive, alt_out, alt_pp;
  int          fail_count, checks_done, cyc;

  gpe_port DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt_en(alt_en),
    .alt_drive(alt_drive), .alt_out(alt_out), .alt_pp(alt_pp), .alt_in(alt_in),
    .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req));

  gpe_pin_model pins (.pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup(pin_pullup), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

  always #2 pclk = ~pclk;

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      conclude;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask

  task automatic rdc(input string n, input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h00000000);
    `CHK(n, e, rd[7:0])
  endtask

  task automatic fetch;
    vector_fetch <= 1'b1;
    @(posedge pclk);
    vector_fetch <= 1'b0;
  endtask

  task automatic t_reset;
    rdc("dir", gpe_pkg::OFS_DIR, gpe_pkg::RST_DIR);
    rdc("opt", gpe_pkg::OFS_OPT, gpe_pkg::RST_OPT);
    `CHK("oe", 8'h00, pin_oe)
    `CHK("pullup", 8'h00, pin_pullup)
    apb(1'b0, 12'h040, 32'h00000000);
    `CHK("slverr", 1'b1, err)
    `CHK("unmapped", 32'h00000000, rd)
    $display("reset test done");
  endtask

  task automatic t_io;
    ext_en  <= 8'hFF;
    ext_val <= 8'hA5;
    wr(gpe_pkg::OFS_DATA, 8'h3C);
    tick(2);
    `CHK("oe in", 8'h00, pin_oe)
    rdc("data in", gpe_pkg::OFS_DATA, 8'hA5);
    wr(gpe_pkg::OFS_DIR, 8'hFF);
    tick(2);
    `CHK("oe od", 8'hC3, pin_oe)
    `CHK("out od", 8'h00, pin_out & pin_oe)
    rdc("data out", gpe_pkg::OFS_DATA, 8'h3C);
    wr(gpe_pkg::OFS_OPT, 8'hFF);
    tick(2);
    `CHK("oe pp", 8'hFF, pin_oe)
    `CHK("out pp", 8'h3C, pin_out)
    wr(gpe_pkg::OFS_DIR, 8'h00);
    tick(2);
    `CHK("pull in", 8'hFF, pin_pullup)
    wr(gpe_pkg::OFS_OPT, 8'h00);
    tick(2);
    `CHK("float in", 8'h00, pin_pullup)
    $display("io test done");
  endtask

  task automatic t_irq;
    logic [3:0] exp;
    exp = 4'hD;
    wr(gpe_pkg::OFS_OPT, 8'h13);
    for (int s = 0; s < 4; s++)
    begin
      ext_val <= 8'hFF;
      tick(3);
      wr(gpe_pkg::OFS_SENS, s[7:0]);
      fetch;
      tick(2);
      `CHK("irq idle", 1'b0, ext_irq_req)
      ext_val <= 8'hFE;
      tick(4);
      `CHK("irq event", exp[s], ext_irq_req)
    end
    fetch;
    tick(2);
    `CHK("irq fetch", 1'b0, ext_irq_req)
    ext_val <= 8'hFC;
    tick(4);
    `CHK("irq or", 1'b1, ext_irq_req)
    wr(gpe_pkg::OFS_SENS, 8'h02);
    tick(2);
    `CHK("irq cancel", 1'b0, ext_irq_req)
    ext_val <= 8'hEC;
    tick(4);
    `CHK("irq std pin", 1'b0, ext_irq_req)
    $display("irq test done");
  endtask

  task automatic t_alt;
    alt_en    <= 8'h0F;
    alt_drive <= 8'h0F;
    alt_out   <= 8'h05;
    alt_pp    <= 8'h03;
    tick(3);
    `CHK("alt oe", 4'hB, pin_oe[3:0])
    `CHK("alt out", 1'b1, pin_out[0])
    `CHK("alt in", 8'hE5, alt_in)
    rdc("alt data", gpe_pkg::OFS_DATA, 8'hE5);
    $display("alt test done");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial
  begin
    {presetn, psel, penable, pwrite, vector_fetch} = '0;
    {paddr, pwdata, ext_en, ext_val} = '0;
    {alt_en, alt_drive, alt_out, alt_pp} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_io;
    t_irq;
    t_alt;
    {alt_en, alt_drive} <= '0;
    presetn <= 1'b0;
    tick(4);
    presetn <= 1'b1;
    t_reset;
    conclude;
  end
endmodule // gpe_port_tb
`default_nettype wire
